// File: rtl/rsc_sequencer.sv
// rail sequencing control with axi4-lite register access
// Function
// - Enable rails from control inputs and earlier rails' power good in slot order.
// - Hold per-rail factory voltage, slot, fault mask and pg routing.
// - An enabled rail has its discharge load disconnected automatically.
// - Software sets each rail's discharge value through discharge registers.
// - Memory rails depend on the two memory enable inputs.
// - Memory supply enables 2 ms after the third converter rail.
// - First auxiliary linear rail enables only after memory supply power good.
// - Termination rail enables after memory supply good when second enable is high.
// - Memory supply is 1.2 V with select low, 1.35 V with select high.
// - Block-memory rail is 0.85 V with select low, 0.9 V with select high.
// - First converter uses sleep voltage code while sleep enable set and select low.
// - Second and third auxiliary rails enable only by register command.
// - Assert external enable and wait for external rail good before continuing.
// - Shared fields drive first auxiliary rail, alias fields drive second load switch.
module rsc_sequencer #(
  parameter int MEM_DLY_CYC = rsc_pkg::MEM_DELAY_MS * rsc_pkg::CLK_HZ / rsc_pkg::MS_PER_S,
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // axi4-lite slave
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // control pins
  input wire logic memEnableA,
  input wire logic memEnableB,
  input wire logic coreSeq,
  input wire logic memVoltSel,
  input wire logic bramVoltSel,
  input wire logic extRailGood,
  // rail power good
  input wire logic [rsc_pkg::NUM_RAILS-1:0] railPowerGood,
  // rail controls
  output logic [rsc_pkg::NUM_RAILS-1:0] railEnable,
  output logic [rsc_pkg::NUM_RAILS-1:0] dischargeOn,
  output logic [rsc_pkg::DIS_W*rsc_pkg::NUM_RAILS-1:0] dischargeSel,
  output logic [7:0] memVcode,
  output logic [7:0] bramVcode,
  output logic [7:0] conv1Vcode,
  output logic [7:0] aux1Vcode,
  output logic extRailEnable
);
  localparam logic [rsc_pkg::CNT_W-1:0] MEM_DLY = (rsc_pkg::CNT_W)'(MEM_DLY_CYC);

  if (MEM_DLY_CYC < 1 || MEM_DLY_CYC >= (1 << rsc_pkg::CNT_W) || ADDR_W < 6) begin : g_chk
    $error("rsc_sequencer: unsupported parameter value");
  end

  logic [rsc_pkg::PIN_W+rsc_pkg::NUM_RAILS-1:0] syncOut;
  logic memAS, memBS, coreS, memVSelS, bramVSelS, extGoodS;
  logic [rsc_pkg::NUM_RAILS-1:0] pgS;
  rsc_pkg::rsc_state_type state_reg;
  logic [3:0] slot_reg;
  logic [rsc_pkg::NUM_RAILS-1:0] seqOn_reg, slotMask;
  logic slotPg, faultHit, extUse, memGo;
  logic [rsc_pkg::CNT_W-1:0] memCnt_reg;
  logic memOn_reg, aux1On_reg, termOn_reg;
  logic [rsc_pkg::CTRL_W-1:0] ctrl_reg;
  logic [7:0] sleepCode_reg, shared_reg;
  logic [7:0] disch_reg [3];
  logic [3:0] linDis_reg;
  logic alias_reg;
  logic awHave_reg, wHave_reg;
  logic [ADDR_W-1:0] awAddr_reg;
  logic [31:0] wData_reg, wMerged;
  logic [3:0] wStrb_reg;
  logic doWrite;

  rsc_sync #(.W(rsc_pkg::PIN_W + rsc_pkg::NUM_RAILS)) u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .d({railPowerGood, extRailGood, bramVoltSel, memVoltSel, coreSeq, memEnableB, memEnableA}),
    .q(syncOut)
  );
  assign {pgS, extGoodS, bramVSelS, memVSelS, coreS, memBS, memAS} = syncOut;

  function automatic logic [7:0] byteAddr(input logic [ADDR_W-1:0] a);
    return 8'(a);
  endfunction

  function automatic logic isMapped(input logic [ADDR_W-1:0] a);
    logic [7:0] b;
    b = byteAddr(a);
    return (a[ADDR_W-1:0] == ADDR_W'(b)) && (b[1:0] == 2'h0) && (b <= rsc_pkg::A_STATUS);
  endfunction

  // sequencer
  assign extUse = ctrl_reg[rsc_pkg::C_EXTUSE];
  always_comb begin
    for (int i = 0; i < rsc_pkg::NUM_RAILS; i++) begin
      slotMask[i] = (rsc_pkg::SEQ_SLOT[i] == slot_reg);
    end
  end
  // slot done when its rails report good
  assign slotPg = &(pgS | ~slotMask);
  // masked rails are exempt from the fault check
  assign faultHit = |(seqOn_reg & ~pgS & ~rsc_pkg::FAULT_MASK);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg <= rsc_pkg::SEQ_OFF;
    end else begin
      unique case (state_reg)
        rsc_pkg::SEQ_OFF: begin
          if (coreS) state_reg <= rsc_pkg::SEQ_CORE;
        end
        rsc_pkg::SEQ_CORE: begin
          if (!coreS) begin
            state_reg <= rsc_pkg::SEQ_OFF;
          end else if (slotPg && slot_reg == rsc_pkg::EXT_SLOT && extUse) begin
            state_reg <= rsc_pkg::SEQ_EXT;
          end else if (slotPg && slot_reg == rsc_pkg::LAST_SLOT) begin
            state_reg <= rsc_pkg::SEQ_ON;
          end
        end
        // hold until the external rail is good
        rsc_pkg::SEQ_EXT: begin
          if (!coreS) begin
            state_reg <= rsc_pkg::SEQ_OFF;
          end else if (extGoodS) begin
            state_reg <= rsc_pkg::SEQ_CORE;
          end
        end
        rsc_pkg::SEQ_ON: begin
          if (!coreS) begin
            state_reg <= rsc_pkg::SEQ_OFF;
          end else if (faultHit) begin
            state_reg <= rsc_pkg::SEQ_FAULT;
          end
        end
        rsc_pkg::SEQ_FAULT: begin
          if (!coreS) state_reg <= rsc_pkg::SEQ_OFF;
        end
        default: state_reg <= rsc_pkg::SEQ_OFF;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst || state_reg == rsc_pkg::SEQ_OFF) begin
      slot_reg <= '0;
    end else if (state_reg == rsc_pkg::SEQ_EXT && extGoodS) begin
      slot_reg <= slot_reg + 4'h1;
    end else if (state_reg == rsc_pkg::SEQ_CORE && slotPg && slot_reg != rsc_pkg::LAST_SLOT
                 && !(slot_reg == rsc_pkg::EXT_SLOT && extUse)) begin
      slot_reg <= slot_reg + 4'h1;
    end
  end

  // rails of the current slot switch on
  always_ff @(posedge sys_clk) begin
    if (rst || !coreS || state_reg == rsc_pkg::SEQ_OFF || state_reg == rsc_pkg::SEQ_FAULT) begin
      seqOn_reg <= '0;
    end else if (state_reg == rsc_pkg::SEQ_CORE) begin
      seqOn_reg <= seqOn_reg | slotMask;
    end
  end

  // memory branch gated by memory enables
  assign memGo = memAS && coreS && seqOn_reg[rsc_pkg::R_CONV3] && pgS[rsc_pkg::R_CONV3];

  always_ff @(posedge sys_clk) begin
    if (rst || !memGo) begin
      memCnt_reg <= '0;
    end else if (memCnt_reg != MEM_DLY) begin
      memCnt_reg <= memCnt_reg + 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      memOn_reg <= 1'b0;
      aux1On_reg <= 1'b0;
      termOn_reg <= 1'b0;
    end else begin
      memOn_reg <= memGo && memCnt_reg == MEM_DLY;
      aux1On_reg <= memGo && memOn_reg && pgS[rsc_pkg::R_MEM];
      termOn_reg <= memGo && memBS && memOn_reg && pgS[rsc_pkg::R_MEM];
    end
  end

  always_comb begin
    railEnable = seqOn_reg;
    railEnable[rsc_pkg::R_MEM] = memOn_reg;
    railEnable[rsc_pkg::R_AUX1] = aux1On_reg;
    railEnable[rsc_pkg::R_TERM] = termOn_reg;
    railEnable[rsc_pkg::R_AUX2] = ctrl_reg[rsc_pkg::C_AUX2];
    railEnable[rsc_pkg::R_AUX3] = ctrl_reg[rsc_pkg::C_AUX3];
    railEnable[rsc_pkg::R_FIRST_LOAD_SWITCH_B] = ctrl_reg[rsc_pkg::C_FIRST_LOAD_SWITCH_B];
    // alias fields steer the second load switch
    railEnable[rsc_pkg::R_SECOND_LOAD_SWITCH_B] = alias_reg;
  end

  assign dischargeOn = ~railEnable;

  always_comb begin
    for (int i = 0; i < rsc_pkg::NUM_RAILS; i++) begin
      dischargeSel[i*rsc_pkg::DIS_W +: rsc_pkg::DIS_W] =
        disch_reg[i / rsc_pkg::DIS_PER_REG][(i % rsc_pkg::DIS_PER_REG)*rsc_pkg::DIS_W +: rsc_pkg::DIS_W];
    end
    // linear/switch discharge register for the shared pair
    dischargeSel[rsc_pkg::R_AUX1*rsc_pkg::DIS_W +: rsc_pkg::DIS_W] = linDis_reg[1:0];
    dischargeSel[rsc_pkg::R_SECOND_LOAD_SWITCH_B*rsc_pkg::DIS_W +: rsc_pkg::DIS_W] = linDis_reg[3:2];
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      memVcode <= rsc_pkg::VC_MEM_LO;
      bramVcode <= rsc_pkg::VC_BRAM_LO;
      conv1Vcode <= rsc_pkg::VC_CONV1_DEF;
      aux1Vcode <= rsc_pkg::VC_AUX1_DEF;
      extRailEnable <= 1'b0;
    end else begin
      memVcode <= memVSelS ? rsc_pkg::VC_MEM_HI : rsc_pkg::VC_MEM_LO;
      bramVcode <= bramVSelS ? rsc_pkg::VC_BRAM_HI : rsc_pkg::VC_BRAM_LO;
      // sleep code applies with select low
      conv1Vcode <= (ctrl_reg[rsc_pkg::C_SLPEN] && !bramVSelS) ? sleepCode_reg
                                                               : rsc_pkg::VC_CONV1_DEF;
      // shared fields steer the auxiliary rail
      aux1Vcode <= shared_reg;
      // external enable follows routed power good
      extRailEnable <= seqOn_reg[rsc_pkg::EXT_PG_RAIL] && pgS[rsc_pkg::EXT_PG_RAIL];
    end
  end

  // axi4-lite write path
  assign s_axi_awready = !awHave_reg;
  assign s_axi_wready = !wHave_reg;
  assign doWrite = awHave_reg && wHave_reg && !s_axi_bvalid;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      awHave_reg <= 1'b0;
      awAddr_reg <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHave_reg <= 1'b1;
      awAddr_reg <= s_axi_awaddr;
    end else if (doWrite) begin
      awHave_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wHave_reg <= 1'b0;
      wData_reg <= '0;
      wStrb_reg <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHave_reg <= 1'b1;
      wData_reg <= s_axi_wdata;
      wStrb_reg <= s_axi_wstrb;
    end else if (doWrite) begin
      wHave_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= rsc_pkg::RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= isMapped(awAddr_reg) ? rsc_pkg::RESP_OKAY : rsc_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  assign wMerged = {wStrb_reg[3] ? wData_reg[31:24] : 8'h00, wStrb_reg[2] ? wData_reg[23:16] : 8'h00,
                    wStrb_reg[1] ? wData_reg[15:8] : 8'h00, wStrb_reg[0] ? wData_reg[7:0] : 8'h00};

  // register file; only the low byte lane carries fields
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_reg <= rsc_pkg::CTRL_RST;
      sleepCode_reg <= rsc_pkg::VC_CONV1_DEF;
      disch_reg <= '{rsc_pkg::DISCH_RST, rsc_pkg::DISCH_RST, rsc_pkg::DISCH_RST};
      linDis_reg <= rsc_pkg::LINDIS_RST;
      shared_reg <= rsc_pkg::VC_AUX1_DEF;
      alias_reg <= 1'b0;
    end else if (doWrite && wStrb_reg[0] && isMapped(awAddr_reg)) begin
      unique case (byteAddr(awAddr_reg))
        rsc_pkg::A_CTRL: ctrl_reg <= wMerged[rsc_pkg::CTRL_W-1:0];
        rsc_pkg::A_SLEEP: sleepCode_reg <= wMerged[7:0];
        rsc_pkg::A_DISCH0: disch_reg[0] <= wMerged[7:0];
        rsc_pkg::A_DISCH1: disch_reg[1] <= wMerged[7:0];
        rsc_pkg::A_DISCH2: disch_reg[2] <= wMerged[7:0];
        rsc_pkg::A_LINDIS: linDis_reg <= wMerged[3:0];
        rsc_pkg::A_SHARED: shared_reg <= wMerged[7:0];
        rsc_pkg::A_ALIAS: alias_reg <= wMerged[0];
        default: ;
      endcase
    end
  end

  // axi4-lite read path
  function automatic logic [31:0] regRead(input logic [ADDR_W-1:0] a);
    logic [31:0] v;
    v = '0;
    unique case (byteAddr(a))
      rsc_pkg::A_CTRL: v[rsc_pkg::CTRL_W-1:0] = ctrl_reg;
      rsc_pkg::A_SLEEP: v[7:0] = sleepCode_reg;
      rsc_pkg::A_DISCH0: v[7:0] = disch_reg[0];
      rsc_pkg::A_DISCH1: v[7:0] = disch_reg[1];
      rsc_pkg::A_DISCH2: v[7:0] = disch_reg[2];
      rsc_pkg::A_LINDIS: v[3:0] = linDis_reg;
      rsc_pkg::A_SHARED: v[7:0] = shared_reg;
      rsc_pkg::A_ALIAS: v[0] = alias_reg;
      rsc_pkg::A_STATUS: begin
        v[rsc_pkg::NUM_RAILS-1:0] = railEnable;
        v[rsc_pkg::ST_PG_LSB +: rsc_pkg::NUM_RAILS] = pgS;
        v[rsc_pkg::ST_FAULT] = (state_reg == rsc_pkg::SEQ_FAULT);
      end
      default: v = '0;
    endcase
    return isMapped(a) ? v : 32'h0000_0000;
  endfunction

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= rsc_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= regRead(s_axi_araddr);
      s_axi_rresp <= isMapped(s_axi_araddr) ? rsc_pkg::RESP_OKAY : rsc_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  disch_release_a: assert property ($rose(railEnable[rsc_pkg::R_MEM]) |->
    !dischargeOn[rsc_pkg::R_MEM] ##1 $past(dischargeOn[rsc_pkg::R_MEM], 2))
    else $error("discharge not released on enable");

  mem_gate_a: assert property ($rose(railEnable[rsc_pkg::R_MEM]) |->
    $past(memAS && coreS))
    else $error("memory supply enabled without enables");

  mem_delay_a: assert property ($rose(memOn_reg) |->
    $past(memCnt_reg) == MEM_DLY && $past(memGo, 2))
    else $error("memory supply delay wrong");

  sequence memGood_s;
    memOn_reg && pgS[rsc_pkg::R_MEM];
  endsequence
  aux_after_pg_a: assert property ($rose(aux1On_reg) |-> $past(memOn_reg && pgS[rsc_pkg::R_MEM]))
    else $error("aux rail before memory good");

  term_order_a: assert property (memGood_s ##0 (memGo && memBS) |=> termOn_reg)
    else $error("termination rail not enabled");

  mem_vsel_a: assert property ($changed(memVSelS) |=>
    memVcode == ($past(memVSelS) ? rsc_pkg::VC_MEM_HI : rsc_pkg::VC_MEM_LO))
    else $error("memory voltage code wrong");

  bram_vsel_a: assert property (bramVSelS [*2] |-> bramVcode == rsc_pkg::VC_BRAM_HI)
    else $error("block memory voltage code wrong");

  sleep_code_a: assert property (ctrl_reg[rsc_pkg::C_SLPEN] && !bramVSelS
    && $stable(sleepCode_reg) |=> conv1Vcode == $past(sleepCode_reg))
    else $error("sleep code not applied");

  cmd_only_a: assert property ($rose(railEnable[rsc_pkg::R_AUX2]) |->
    $past(doWrite && byteAddr(awAddr_reg) == rsc_pkg::A_CTRL))
    else $error("aux rail enabled without command");

  ext_wait_a: assert property (state_reg == rsc_pkg::SEQ_EXT && !extGoodS && coreS |=>
    state_reg == rsc_pkg::SEQ_EXT && $stable(slot_reg))
    else $error("sequence left external slot early");
endmodule // rsc_sequencer

// File: rtl/rsc_pkg.sv
// constants, register map and types of the rail sequencing control block
package rsc_pkg;
  localparam int CLK_HZ = 10_000_000;
  localparam int MS_PER_S = 1000;
  localparam int MEM_DELAY_MS = 2;
  localparam int CNT_W = 16;
  localparam int NUM_RAILS = 10;
  localparam int PIN_W = 6;
  // rail indices
  localparam int R_BRAM = 0;
  localparam int R_CONV1 = 1;
  localparam int R_CONV3 = 2;
  localparam int R_MEM = 3;
  localparam int R_AUX1 = 4;
  localparam int R_AUX2 = 5;
  localparam int R_AUX3 = 6;
  localparam int R_TERM = 7;
  localparam int R_FIRST_LOAD_SWITCH_B = 8;
  localparam int R_SECOND_LOAD_SWITCH_B = 9;
  // factory settings per rail: sequence slot, fault mask, pg routed to the external enable
  localparam logic [3:0] NO_SLOT = 4'hf;
  localparam logic [3:0] SEQ_SLOT [NUM_RAILS] = '{4'h0, 4'h1, 4'h2, NO_SLOT, NO_SLOT,
    NO_SLOT, NO_SLOT, NO_SLOT, NO_SLOT, NO_SLOT};
  localparam logic [3:0] LAST_SLOT = 4'h2;
  localparam logic [3:0] EXT_SLOT = 4'h0;
  localparam logic [NUM_RAILS-1:0] FAULT_MASK = 10'h360;
  localparam int EXT_PG_RAIL = R_BRAM;
  // voltage codes in 10 mV units
  localparam logic [7:0] VC_MEM_LO = 8'h78;
  localparam logic [7:0] VC_MEM_HI = 8'h87;
  localparam logic [7:0] VC_BRAM_LO = 8'h55;
  localparam logic [7:0] VC_BRAM_HI = 8'h5a;
  localparam logic [7:0] VC_CONV1_DEF = 8'h78;
  localparam logic [7:0] VC_AUX1_DEF = 8'hfa;
  // register byte addresses
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_SLEEP = 8'h04;
  localparam logic [7:0] A_DISCH0 = 8'h08;
  localparam logic [7:0] A_DISCH1 = 8'h0c;
  localparam logic [7:0] A_DISCH2 = 8'h10;
  localparam logic [7:0] A_LINDIS = 8'h14;
  localparam logic [7:0] A_SHARED = 8'h18;
  localparam logic [7:0] A_ALIAS = 8'h1c;
  localparam logic [7:0] A_STATUS = 8'h20;
  // control register fields and reset values
  localparam int C_AUX2 = 0;
  localparam int C_AUX3 = 1;
  localparam int C_EXTUSE = 2;
  localparam int C_SLPEN = 3;
  localparam int C_FIRST_LOAD_SWITCH_B = 4;
  localparam int CTRL_W = 5;
  localparam logic [CTRL_W-1:0] CTRL_RST = 5'h0c;
  localparam int DIS_W = 2;
  localparam int DIS_PER_REG = 4;
  localparam logic [7:0] DISCH_RST = 8'h55;
  localparam logic [3:0] LINDIS_RST = 4'h5;
  localparam int ST_PG_LSB = 16;
  localparam int ST_FAULT = 31;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {SEQ_OFF, SEQ_CORE, SEQ_EXT, SEQ_ON, SEQ_FAULT} rsc_state_type;
endpackage

// File: rtl/rsc_sync.sv
// two-stage synchroniser for a vector of levels
module rsc_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule // rsc_sync

// File: dv/rsc_rail_model.sv
// partner model: rail power good answers and the external regulator
module rsc_rail_model #(
  parameter int PGD = 3,
  parameter int EXD = 7
) (
  // clock
  input wire logic sys_clk,
  // enables from the sequencer
  input wire logic [rsc_pkg::NUM_RAILS-1:0] railEnable,
  input wire logic extRailEnable,
  // answers
  output logic [rsc_pkg::NUM_RAILS-1:0] railPowerGood,
  output logic extRailGood
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt [rsc_pkg::NUM_RAILS];
  int extCnt;
  initial begin
    railPowerGood = '0;
    extRailGood = 1'b0;
  end
  // pg after a ramp, dropped at once on disable
  always @(posedge sys_clk) begin
    for (int i = 0; i < rsc_pkg::NUM_RAILS; i++) begin
      cnt[i] = railEnable[i] ? cnt[i] + 1 : 0;
      railPowerGood[i] <= cnt[i] > PGD;
    end
  end
  always @(posedge sys_clk) begin
    extCnt = extRailEnable ? extCnt + 1 : 0;
    extRailGood <= extCnt > EXD;
  end
endmodule // rsc_rail_model

// File: dv/rail_sequencing_control_tb.sv
// self-checking bench of the rail sequencing control block
module rail_sequencing_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int MEMD = 20;
  localparam int PGD = 3;
  logic sys_clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, extRailEnable;
  logic [7:0] awaddr, araddr, memVcode, bramVcode, conv1Vcode, aux1Vcode, v;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic memEnableA, memEnableB, coreSeq, memVoltSel, bramVoltSel, extRailGood;
  logic [9:0] railPowerGood, railEnable, dischargeOn, railEnPrev;
  logic [19:0] dischargeSel;
  int n_mismatch, n_compared, c3;

  rsc_sequencer #(.MEM_DLY_CYC(MEMD), .ADDR_W(8)) dut (
    .sys_clk(sys_clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .memEnableA(memEnableA), .memEnableB(memEnableB), .coreSeq(coreSeq),
    .memVoltSel(memVoltSel), .bramVoltSel(bramVoltSel), .extRailGood(extRailGood),
    .railPowerGood(railPowerGood), .railEnable(railEnable), .dischargeOn(dischargeOn),
    .dischargeSel(dischargeSel), .memVcode(memVcode), .bramVcode(bramVcode),
    .conv1Vcode(conv1Vcode), .aux1Vcode(aux1Vcode), .extRailEnable(extRailEnable));

  rsc_rail_model #(.PGD(PGD), .EXD(7)) partner (
    .sys_clk(sys_clk), .railEnable(railEnable), .extRailEnable(extRailEnable),
    .railPowerGood(railPowerGood), .extRailGood(extRailGood));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  function automatic logic [7:0] vexp(input logic s, input logic [7:0] lo, input logic [7:0] hi);
    return s ? hi : lo;
  endfunction

  // address and data offered together, each released once taken
  task automatic axw(input logic [7:0] a, input logic [31:0] dat);
    logic ad, dd;
    ad = 1'b0;
    dd = 1'b0;
    awaddr <= a;
    wdata <= dat;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ad && dd)) begin
      @(posedge sys_clk);
      ad = ad | awready;
      dd = dd | wready;
      if (ad) awvalid <= 1'b0;
      if (dd) wvalid <= 1'b0;
    end
    do @(posedge sys_clk); while (!bvalid);
    r = bresp;
  endtask

  task automatic axr(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge sys_clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge sys_clk); while (!rvalid);
    d = rdata;
    r = rresp;
  endtask

  task close_out;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ordering monitor on enable edges
  always @(posedge sys_clk) begin
    railEnPrev <= railEnable;
    c3 <= (railEnable[2] && !railEnPrev[2]) ? 0 : c3 + 1;
    if (!rst) begin
      chk("dischargeOn", dischargeOn ^ railEnable, 10'h3ff);
      if (railEnable[1] && !railEnPrev[1]) chk("extGood", {extRailEnable, extRailGood}, 2'b11);
      if (railEnable[3] && !railEnPrev[3]) chk("memDelay", c3 >= MEMD && c3 <= MEMD + PGD + 10, 1);
      if (railEnable[4] && !railEnPrev[4]) chk("aux1Order", railPowerGood[3], 1);
      if (railEnable[7] && !railEnPrev[7]) chk("termOrder", {railPowerGood[3], memEnableB}, 2'b11);
    end
  end

  initial begin
    step(5000);
    $display("watchdog expired");
    n_mismatch++;
    close_out;
  end

  initial begin
    rst = 1'b1;
    {awaddr, araddr, wdata, awvalid, wvalid, arvalid} = '0;
    {memEnableA, memEnableB, coreSeq, memVoltSel, bramVoltSel} = '0;
    wstrb = 4'hf;
    bready = 1'b1;
    rready = 1'b1;
    void'($urandom(58));
    step(6);
    rst <= 1'b0;
    step(1);
    chk("railEnable", railEnable, 0);
    chk("vcodes", {memVcode, bramVcode, conv1Vcode, aux1Vcode}, 32'h785578fa);
    axr(rsc_pkg::A_CTRL);
    chk("ctrl", d, 32'h0c);
    axr(rsc_pkg::A_DISCH0);
    chk("disch0", d, 32'h55);
    axr(8'h24);
    chk("unmapped", r, rsc_pkg::RESP_SLVERR);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      memVoltSel <= 1'($urandom);
      bramVoltSel <= i[0];
      v = (i == 0) ? 8'hff : 8'($urandom);
      axw(rsc_pkg::A_SLEEP, {24'h0, v});
      axw(rsc_pkg::A_DISCH0, {24'h0, v});
      chk("bresp", r, rsc_pkg::RESP_OKAY);
      step(4);
      chk("memVcode", memVcode, vexp(memVoltSel, 8'h78, 8'h87));
      chk("bramVcode", bramVcode, vexp(bramVoltSel, 8'h55, 8'h5a));
      chk("conv1Vcode", conv1Vcode, vexp(bramVoltSel, v, 8'h78));
      chk("dischargeSel", dischargeSel[7:0], v);
    end
    $display("test selects done");
    for (int i = 1; i < 4; i++) begin
      memEnableA <= i[0];
      memEnableB <= i[1];
      coreSeq <= 1'b1;
      for (int k = 0; k < 300 && !railEnable[2]; k++) step(1);
      step(MEMD + 40);
      chk("seqRails", railEnable, {2'b0, i[0] & i[1], 2'b0, {2{i[0]}}, 3'b111});
      coreSeq <= 1'b0;
      step(6);
      chk("seqOff", railEnable, 0);
    end
    $display("test sequence done");
    memEnableA <= 1'b1;
    axw(rsc_pkg::A_CTRL, 32'h0f);
    axw(rsc_pkg::A_ALIAS, 32'h1);
    v = 8'($urandom);
    axw(rsc_pkg::A_SHARED, {24'h0, v});
    step(2);
    chk("regRails", railEnable, 10'h260);
    chk("aux1Vcode", aux1Vcode, v);
    axr(rsc_pkg::A_STATUS);
    chk("status", d[9:0], 10'h260);
    axw(rsc_pkg::A_CTRL, 32'h1c);
    step(2);
    chk("switches", railEnable, 10'h300);
    $display("test register rails done");
    close_out;
  end
endmodule // rail_sequencing_control_tb
